// >>> hdl/i2cm_defs.svh
// Register offsets, field positions and reset values of the bus controller
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

`define I2CM_ADDR_W 3
`define I2CM_OFS_DATA 3'h0
`define I2CM_OFS_STAT 3'h1
`define I2CM_OFS_CTRL 3'h2
`define I2CM_OFS_DIVH 3'h3
`define I2CM_OFS_DIVL 3'h4

// Control register fields
`define I2CM_CTL_EN 7
`define I2CM_CTL_START 6
`define I2CM_CTL_STOP 5
`define I2CM_CTL_DIVIRQ 4
`define I2CM_CTL_TXIE 3
`define I2CM_CTL_NAK 2
`define I2CM_CTL_FLUSH 1

// Status register fields
`define I2CM_ST_TXE 7
`define I2CM_ST_RXF 6
`define I2CM_ST_NACKI 5
`define I2CM_ST_ACK 4
`define I2CM_ST_BUSY 3

`define I2CM_CTRL_RST 8'h00
`define I2CM_DATA_RST 8'h00
`define I2CM_DIV_RST 16'h0010
`define I2CM_LAST_BIT 3'h7

`endif

// >>> hdl/i2cm_pkg.sv
// Types shared by the bus controller modules
package i2cm_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_BIT_LO = 4'b0010,
    ST_BIT_HI = 4'b0011,
    ST_ACK_LO = 4'b0100,
    ST_ACK_HI = 4'b0101,
    ST_HOLD = 4'b0110,
    ST_STOP_A = 4'b0111,
    ST_STOP_B = 4'b1000,
    ST_STOP_C = 4'b1001,
    ST_RS_A = 4'b1010,
    ST_RS_B = 4'b1011
  } i2cm_state_t;
endpackage

// >>> hdl/i2cm_brg_if.sv
// Link between the controller and its baud rate divider
`timescale 1ns/10ps
interface i2cm_div_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor;
  logic run;
  logic tick;
  modport ctrl (output divisor, output run, input tick);
  modport cnt (input divisor, input run, output tick);
endinterface

// >>> hdl/i2cm_brg.sv
// Baud rate divider: one tick each time the count reaches one
`timescale 1ns/10ps
module i2cm_div #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  i2cm_div_if.cnt bus
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire at_one = (cnt_q <= {{(DIV_W-1){1'b0}}, 1'b1});

  // A divisor of zero or one ticks on every clock
  assign cnt_d = (!bus.run || at_one) ? bus.divisor
                                      : cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
  assign bus.tick = bus.run && at_one;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> hdl/i2cm_ctrl.sv
// Two-wire bus master: transmit path, registers and baud timer
//
// Functional notes
// - Data register write clears transmit-empty flag
// - Empty flag stalls at acknowledge phase start
// - Disabled with select set, divider ticks interrupt
// - Empty flag asserts regardless of interrupt enable
// - Transmit interrupt and request need enable
// - Status shows empty, full and nack flags
// - Nack sets flag, holds until stop/start
// - No nack interrupt after stop-marked byte
// - Empty flag at first bit of each byte
// - Start bit issues start then loads shifter
// - First address bit out raises empty flag
// - Remaining bits shift out autonomously
// - Low data line at acknowledge sets ack
// - Nack sets flag, clears ack, interrupts
// - Stop clears stop bit and nack flag
`timescale 1ns/10ps
`include "i2cm_defs.svh"
module i2cm_ctrl #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`I2CM_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Requests to the system
  output logic irq,
  output logic dma_tx_req,
  // Serial bus pins, enables active low
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  // The divisor register is two bytes, so no wider counter has a source
  if (DIV_W < 8 || DIV_W > 16) begin : g_div_w_check
    $error("i2cm_ctrl: DIV_W must lie in 8..16");
  end

  i2cm_div_if #(.DIV_W(DIV_W)) div_bus ();
  i2cm_div #(.DIV_W(DIV_W)) u_div (
    .clk(clk),
    .rst(rst),
    .bus(div_bus)
  );

  i2cm_pkg::i2cm_state_t st_q;
  i2cm_pkg::i2cm_state_t st_d;
  logic [7:0] data_q;
  logic [7:0] shift_q;
  logic [2:0] bcnt_q;
  logic [15:0] div_q;
  logic en_q;
  logic div_irq_sel_q;
  logic tx_int_en_q;
  logic nak_q;
  logic start_q;
  logic stop_q;
  logic tx_empty_flag;
  logic nack_interrupt_flag;
  logic rx_full_flag;
  logic ack_q;
  logic sda_m_q;
  logic sda_s_q;
  logic scl_low_q;
  logic sda_low_q;
  logic [7:0] rdata_q;

  function automatic logic hit(input logic [`I2CM_ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire tick = div_bus.tick;
  wire wr_data = wr && hit(`I2CM_OFS_DATA);
  wire wr_ctrl = wr && hit(`I2CM_OFS_CTRL);
  wire flush = wr_ctrl && wdata[`I2CM_CTL_FLUSH];
  wire last_or_restart = stop_q || start_q;
  wire first_bit_out = (st_q == i2cm_pkg::ST_BIT_HI) && tick &&
                       (bcnt_q == `I2CM_LAST_BIT);
  wire ack_sample = (st_q == i2cm_pkg::ST_ACK_HI) && tick;
  wire got_ack = ack_sample && !sda_s_q;
  wire got_nack = ack_sample && sda_s_q;
  wire take_start = (st_q == i2cm_pkg::ST_IDLE) && tick && en_q &&
                    start_q && !tx_empty_flag;
  wire load_shift = (st_q == i2cm_pkg::ST_START) && tick;
  wire stop_done = (st_q == i2cm_pkg::ST_STOP_C) && tick;
  wire div_event = div_bus.tick && !en_q && div_irq_sel_q;
  wire [7:0] status = {tx_empty_flag, rx_full_flag, nack_interrupt_flag,
                       ack_q, (st_q != i2cm_pkg::ST_IDLE), 3'h0};
  wire [7:0] control = {en_q, start_q, stop_q, div_irq_sel_q, tx_int_en_q,
                        nak_q, 2'h0};

  assign div_bus.divisor = div_q[DIV_W-1:0];
  assign div_bus.run = en_q || div_irq_sel_q;

  // Bit sequencer, advancing one phase per divider tick
  always_comb begin
    st_d = st_q;
    case (st_q)
      i2cm_pkg::ST_IDLE: if (take_start) st_d = i2cm_pkg::ST_START;
      i2cm_pkg::ST_START: if (tick) st_d = i2cm_pkg::ST_BIT_LO;
      i2cm_pkg::ST_BIT_LO: if (tick) st_d = i2cm_pkg::ST_BIT_HI;
      i2cm_pkg::ST_BIT_HI: begin
        if (tick) begin
          st_d = (bcnt_q == 3'h0) ? i2cm_pkg::ST_ACK_LO
                                  : i2cm_pkg::ST_BIT_LO;
        end
      end
      i2cm_pkg::ST_ACK_LO: begin
        // Parked here with the clock low until a byte or end arrives
        if (tick && (!tx_empty_flag || last_or_restart)) begin
          st_d = i2cm_pkg::ST_ACK_HI;
        end
      end
      i2cm_pkg::ST_ACK_HI: begin
        if (tick) begin
          if (stop_q) st_d = i2cm_pkg::ST_STOP_A;
          else if (sda_s_q) st_d = i2cm_pkg::ST_HOLD;
          else if (start_q) st_d = i2cm_pkg::ST_RS_A;
          else st_d = i2cm_pkg::ST_BIT_LO;
        end
      end
      i2cm_pkg::ST_HOLD: begin
        if (tick && stop_q) st_d = i2cm_pkg::ST_STOP_A;
        else if (tick && start_q) st_d = i2cm_pkg::ST_RS_A;
      end
      i2cm_pkg::ST_STOP_A: if (tick) st_d = i2cm_pkg::ST_STOP_B;
      i2cm_pkg::ST_STOP_B: if (tick) st_d = i2cm_pkg::ST_STOP_C;
      i2cm_pkg::ST_STOP_C: if (tick) st_d = i2cm_pkg::ST_IDLE;
      i2cm_pkg::ST_RS_A: if (tick) st_d = i2cm_pkg::ST_RS_B;
      i2cm_pkg::ST_RS_B: if (tick) st_d = i2cm_pkg::ST_START;
      default: st_d = i2cm_pkg::ST_IDLE;
    endcase
    if (!en_q) begin
      st_d = i2cm_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= i2cm_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Shifter: a fresh byte is taken at start and after each ack not followed by stop or a repeated start
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= 8'h00;
      bcnt_q <= 3'h0;
    end else if (load_shift || (ack_sample && st_d == i2cm_pkg::ST_BIT_LO)) begin
      shift_q <= data_q;
      bcnt_q <= `I2CM_LAST_BIT;
    end else if ((st_q == i2cm_pkg::ST_BIT_HI) && tick) begin
      shift_q <= {shift_q[6:0], 1'b0};
      bcnt_q <= bcnt_q - 3'h1;
    end
  end

  // Transmit-empty: the hardware set wins over a same-cycle write
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_empty_flag <= 1'b1;
    end else if (first_bit_out || flush) begin
      tx_empty_flag <= 1'b1;
    end else if (wr_data) begin
      tx_empty_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= `I2CM_DATA_RST;
    end else if (wr_data) begin
      data_q <= wdata;
    end
  end

  // Acknowledge and not-acknowledge flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      nack_interrupt_flag <= 1'b0;
    end else begin
      if (got_ack) begin
        ack_q <= 1'b1;
      end else if (got_nack) begin
        ack_q <= 1'b0;
      end
      if (got_nack && !stop_q) begin
        nack_interrupt_flag <= 1'b1;
      end else if (stop_done) begin
        nack_interrupt_flag <= 1'b0;
      end
    end
  end

  // Receive path lives elsewhere; the flag is kept for software polling
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_full_flag <= 1'b0;
    end else if (rd && hit(`I2CM_OFS_DATA)) begin
      rx_full_flag <= 1'b0;
    end
  end

  // Control register; start and stop clear themselves once served
  always_ff @(posedge clk) begin
    if (rst) begin
      {en_q, start_q, stop_q, div_irq_sel_q, tx_int_en_q, nak_q} <= 6'h00;
    end else if (wr_ctrl) begin
      en_q <= wdata[`I2CM_CTL_EN];
      start_q <= wdata[`I2CM_CTL_START];
      stop_q <= wdata[`I2CM_CTL_STOP];
      div_irq_sel_q <= wdata[`I2CM_CTL_DIVIRQ];
      tx_int_en_q <= wdata[`I2CM_CTL_TXIE];
      nak_q <= wdata[`I2CM_CTL_NAK];
    end else begin
      if (load_shift) start_q <= 1'b0;
      if (stop_done) stop_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= `I2CM_DIV_RST;
    end else if (wr && hit(`I2CM_OFS_DIVH)) begin
      div_q[15:8] <= wdata;
    end else if (wr && hit(`I2CM_OFS_DIVL)) begin
      div_q[7:0] <= wdata;
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (addr)
        `I2CM_OFS_DATA: rdata_q <= data_q;
        `I2CM_OFS_STAT: rdata_q <= status;
        `I2CM_OFS_CTRL: rdata_q <= control;
        `I2CM_OFS_DIVH: rdata_q <= div_q[15:8];
        `I2CM_OFS_DIVL: rdata_q <= div_q[7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_q;

  // Requests: transmit side gated by its enable
  assign dma_tx_req = en_q && tx_int_en_q && tx_empty_flag;
  assign irq = dma_tx_req || nack_interrupt_flag || rx_full_flag ||
               div_event;

  // Pad sampling through two flops before any use
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // Pin drive registered from the state so edges are glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      scl_low_q <= (st_q == i2cm_pkg::ST_BIT_LO) ||
                   (st_q == i2cm_pkg::ST_ACK_LO) ||
                   (st_q == i2cm_pkg::ST_HOLD) ||
                   (st_q == i2cm_pkg::ST_STOP_A) ||
                   (st_q == i2cm_pkg::ST_RS_A);
      sda_low_q <= (st_q == i2cm_pkg::ST_START) ||
                   (st_q == i2cm_pkg::ST_STOP_A) ||
                   (st_q == i2cm_pkg::ST_STOP_B) ||
                   (((st_q == i2cm_pkg::ST_BIT_LO) ||
                     (st_q == i2cm_pkg::ST_BIT_HI)) && !shift_q[7]);
    end
  end
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !scl_low_q;
  assign sda_oe_n = !sda_low_q;

  // Checks
  property p_wr_clears;
    @(posedge clk) disable iff (rst)
    wr_data && !first_bit_out && !flush |=> !tx_empty_flag;
  endproperty
  a_wr_clears: assert property (p_wr_clears)
    else $error("data write did not clear the empty flag");

  property p_ack_stall;
    @(posedge clk) disable iff (rst)
    (st_q == i2cm_pkg::ST_ACK_LO) && tx_empty_flag && !last_or_restart &&
    en_q && !wr_ctrl |=> (st_q == i2cm_pkg::ST_ACK_LO);
  endproperty
  a_ack_stall: assert property (p_ack_stall)
    else $error("controller left the acknowledge stall");

  property p_div_irq;
    @(posedge clk) disable iff (rst)
    div_bus.tick && !en_q && div_irq_sel_q |-> irq;
  endproperty
  a_div_irq: assert property (p_div_irq)
    else $error("divider tick gave no interrupt");

  // Any interrupt not owed to nack, receive or timer is a transmit one
  property p_tx_gate;
    @(posedge clk) disable iff (rst)
    dma_tx_req || (irq && !nack_interrupt_flag && !rx_full_flag &&
    !div_event) |-> tx_int_en_q && tx_empty_flag;
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("transmit request without enable");

  property p_nack_hold;
    @(posedge clk) disable iff (rst)
    (st_q == i2cm_pkg::ST_HOLD) && !stop_q && !start_q && en_q &&
    !wr_ctrl |=> (st_q == i2cm_pkg::ST_HOLD);
  endproperty
  a_nack_hold: assert property (p_nack_hold)
    else $error("paused transfer resumed without stop or start");

  property p_no_nacki_stop;
    @(posedge clk) disable iff (rst)
    got_nack && stop_q && !nack_interrupt_flag |=> !nack_interrupt_flag;
  endproperty
  a_no_nacki_stop: assert property (p_no_nacki_stop)
    else $error("nack flag raised after stop was set");

  property p_first_bit;
    @(posedge clk) disable iff (rst)
    first_bit_out |=> tx_empty_flag ##1 ($past(bcnt_q) == 3'h6);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("empty flag not raised after first bit");

  property p_ack_set;
    @(posedge clk) disable iff (rst)
    got_ack |=> ack_q && $stable(nack_interrupt_flag);
  endproperty
  a_ack_set: assert property (p_ack_set)
    else $error("acknowledge not recorded");

  property p_stop_clear;
    @(posedge clk) disable iff (rst)
    stop_done && !wr_ctrl |=> !stop_q && !nack_interrupt_flag &&
                              (st_q == i2cm_pkg::ST_IDLE);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop did not clear stop bit and nack flag");

  property p_flush;
    @(posedge clk) disable iff (rst)
    flush |=> tx_empty_flag;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush left the empty flag low");

  property p_start_seq;
    @(posedge clk) disable iff (rst)
    take_start |=> (st_q == i2cm_pkg::ST_START) ##1 (!sda_oe_n && scl_oe_n);
  endproperty
  a_start_seq: assert property (p_start_seq)
    else $error("start condition not issued");

  c_start: cover property (@(posedge clk) disable iff (rst) take_start);
  c_nack: cover property (@(posedge clk) disable iff (rst) got_nack);
  c_stall: cover property (@(posedge clk) disable iff (rst)
    (st_q == i2cm_pkg::ST_ACK_LO) && tx_empty_flag [*3]);
  c_stop: cover property (@(posedge clk) disable iff (rst) stop_done);
endmodule

// >>> dv/i2cm_slave_model.sv
// Behavioural two-wire slave that acknowledges or refuses each byte
`timescale 1ns/10ps
module i2cm_slave_model (
  // Clock and bus lines
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Test control
  input wire logic nack_mode,
  // Open-drain pull and observations
  output logic sda_pull,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_cnt,
  output logic [7:0] starts,
  output logic [7:0] stops
);
  logic scl_p, sda_p;
  logic [3:0] bitcnt;
  logic [7:0] sh;
  initial begin
    {scl_p, sda_p, sda_pull} = 3'b110;
    {bitcnt, sh, rx_byte, rx_cnt, starts, stops} = '0;
  end
  // Lines are sampled on the system clock; edges are seen one clock late
  always @(posedge clk) begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && scl_p && sda_p && !sda) begin
      starts <= starts + 8'h01;
      bitcnt <= 4'h0;
    end
    if (scl && scl_p && !sda_p && sda)
      stops <= stops + 8'h01;
    if (scl && !scl_p && bitcnt < 4'h8) begin
      sh <= {sh[6:0], sda};
      bitcnt <= bitcnt + 4'h1;
    end
    if (!scl && scl_p && bitcnt == 4'h8) begin
      sda_pull <= !nack_mode;
      rx_byte <= sh;
      rx_cnt <= rx_cnt + 8'h01;
      bitcnt <= 4'h9;
    end
    // Released after the acknowledge slot, so the pull-up shows high
    if (!scl && scl_p && bitcnt == 4'h9) begin
      sda_pull <= 1'b0;
      bitcnt <= 4'h0;
    end
  end
endmodule

// >>> dv/i2c_master_transfer_control_tb_top.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/10ps
`include "i2cm_defs.svh"
module i2c_master_transfer_control_tb_top;
  localparam logic [7:0] c_en = 8'h01 << `I2CM_CTL_EN;
  localparam logic [7:0] c_go = 8'h01 << `I2CM_CTL_START;
  localparam logic [7:0] c_stp = 8'h01 << `I2CM_CTL_STOP;
  localparam logic [7:0] c_bq = 8'h01 << `I2CM_CTL_DIVIRQ;
  localparam logic [7:0] c_tie = 8'h01 << `I2CM_CTL_TXIE;
  localparam logic [7:0] c_nk = 8'h01 << `I2CM_CTL_NAK;
  localparam logic [7:0] c_fl = 8'h01 << `I2CM_CTL_FLUSH;
  localparam logic [2:0] a_dt = `I2CM_OFS_DATA;
  localparam logic [2:0] a_st = `I2CM_OFS_STAT;
  localparam logic [2:0] a_ct = `I2CM_OFS_CTRL;
  logic clk, rst, wr, rd, nack_mode, irq, dma_tx_req, sda_pull;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [`I2CM_ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, rx_byte, rx_cnt, starts, stops;
  logic [7:0] v, b0, b1, r0, s0, g0;
  logic [2:0] ra [5];
  logic [7:0] re [5];
  int err_count, n_checks, cyc, t0, c;
  // Open-drain lines with pull-ups: released means high
  wire logic scl = scl_oe_n ? 1'b1 : scl_out;
  wire logic sda = (sda_oe_n ? 1'b1 : sda_out) & ~sda_pull;

  i2cm_ctrl #(.DIV_W(16)) DUT (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .dma_tx_req(dma_tx_req), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));
  i2cm_slave_model slave (
    .clk(clk), .scl(scl), .sda(sda), .nack_mode(nack_mode),
    .sda_pull(sda_pull), .rx_byte(rx_byte), .rx_cnt(rx_cnt),
    .starts(starts), .stops(stops));

  function automatic logic [7:0] st_exp(logic t, logic n, logic a,
    logic b);
    logic [7:0] s;
    s = 8'h00;
    s[`I2CM_ST_TXE] = t;
    s[`I2CM_ST_NACKI] = n;
    s[`I2CM_ST_ACK] = a;
    s[`I2CM_ST_BUSY] = b;
    return s;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_st(input int b, input logic val);
    for (int i = 0; i < 300; i++) begin
      rd_reg(a_st, v);
      if (v[b] === val)
        return;
    end
    chk(v[b], val);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1)
        return;
    end
    chk(irq, 1'b1);
  endtask
  task automatic done(input int n);
    $display("test %0d finished at %0t", n, $time);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs under a thousand cycles; this ceiling cuts a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {wr, rd, addr, wdata, nack_mode} = '0;
    rst = 1'b1;
    void'($urandom(32'hfe21));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values; the unmapped write must change nothing
    wr_reg(3'h5, 8'($urandom));
    ra = '{a_st, a_ct, `I2CM_OFS_DIVH, `I2CM_OFS_DIVL, 3'h5};
    re = '{st_exp(1, 0, 0, 0), `I2CM_CTRL_RST, 8'(`I2CM_DIV_RST >> 8),
      8'(`I2CM_DIV_RST), 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd_reg(ra[i], v);
      chk(v, re[i]);
    end
    done(1);
    // Acked write, then a stall while no next byte is supplied
    wr_reg(`I2CM_OFS_DIVH, 8'h00);
    // Three clocks a phase: the synchronised ack must settle before sampling
    wr_reg(`I2CM_OFS_DIVL, 8'h03);
    wr_reg(a_ct, c_en);
    #1 chk({irq, dma_tx_req}, 2'b00);
    rd_reg(a_st, v);
    chk(v, st_exp(1, 0, 0, 0));
    wr_reg(a_ct, c_en | c_tie);
    #1 chk({irq, dma_tx_req}, 2'b11);
    b0 = {7'($urandom), 1'b0};
    b1 = 8'($urandom);
    {r0, s0, g0} = {rx_cnt, stops, starts};
    wr_reg(a_dt, b0);
    #1 chk({irq, dma_tx_req}, 2'b00);
    wr_reg(a_ct, c_en | c_go | c_tie);
    wait_st(`I2CM_ST_TXE, 1'b1);
    chk(v, st_exp(1, 0, 0, 1));
    chk(starts, g0 + 8'h01);
    wr_reg(a_dt, b1);
    wait_st(`I2CM_ST_TXE, 1'b1);
    chk(v, st_exp(1, 0, 1, 1));
    chk(rx_byte, b0);
    repeat (80) @(posedge clk);
    chk(rx_cnt, r0 + 8'h02);
    chk(rx_byte, b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1 chk({scl, dma_tx_req}, 2'b01);
    end
    wr_reg(a_ct, c_en | c_stp | c_tie);
    wait_st(`I2CM_ST_BUSY, 1'b0);
    chk(v, st_exp(1, 0, 1, 0));
    chk(stops, s0 + 8'h01);
    chk({scl, sda}, 2'b11);
    rd_reg(a_ct, v);
    chk(v, c_en | c_tie);
    done(2);
    // Refused byte: flag, pause, then stop with flush
    @(posedge clk);
    nack_mode <= 1'b1;
    {r0, s0} = {rx_cnt, stops};
    wr_reg(a_ct, c_en);
    wr_reg(a_dt, b0);
    wr_reg(a_ct, c_en | c_go);
    wait_st(`I2CM_ST_TXE, 1'b1);
    #1 chk({irq, dma_tx_req}, 2'b00);
    wr_reg(a_dt, b1);
    wait_st(`I2CM_ST_NACKI, 1'b1);
    chk(v, st_exp(0, 1, 0, 1));
    #1 chk(irq, 1'b1);
    repeat (40) @(posedge clk);
    rd_reg(a_st, v);
    chk(v, st_exp(0, 1, 0, 1));
    chk(rx_cnt, r0 + 8'h01);
    chk(scl, 1'b0);
    wr_reg(a_ct, c_en | c_stp | c_fl);
    wait_st(`I2CM_ST_BUSY, 1'b0);
    chk(v, st_exp(1, 0, 0, 0));
    chk(stops, s0 + 8'h01);
    rd_reg(a_ct, v);
    chk(v, c_en);
    done(3);
    // Refused byte answered by a repeated start, then stop with flush
    {r0, g0} = {rx_cnt, starts};
    wr_reg(a_dt, b0);
    wr_reg(a_ct, c_en | c_go);
    wait_st(`I2CM_ST_TXE, 1'b1);
    wr_reg(a_dt, b1);
    wait_st(`I2CM_ST_NACKI, 1'b1);
    wr_reg(a_ct, c_en | c_go);
    wait_st(`I2CM_ST_TXE, 1'b1);
    chk(v, st_exp(1, 1, 0, 1));
    chk(starts, g0 + 8'h02);
    wr_reg(a_ct, c_en | c_stp | c_fl);
    wait_st(`I2CM_ST_BUSY, 1'b0);
    chk(v, st_exp(1, 0, 0, 0));
    chk(rx_cnt, r0 + 8'h02);
    done(4);
    // Refusal of a byte already marked as the last one
    s0 = stops;
    wr_reg(a_dt, b0);
    wr_reg(a_ct, c_en | c_go);
    wait_st(`I2CM_ST_TXE, 1'b1);
    wr_reg(a_ct, c_en | c_stp);
    wait_st(`I2CM_ST_BUSY, 1'b0);
    chk(v, st_exp(1, 0, 0, 0));
    #1 chk(irq, 1'b0);
    chk(stops, s0 + 8'h01);
    done(5);
    // Divider as a general timer while the controller is off
    for (int k = 0; k < 3; k++) begin
      b0 = 8'(2 + $urandom % 7);
      wr_reg(`I2CM_OFS_DIVL, b0);
      wr_reg(a_ct, c_bq);
      wait_irq();
      wait_irq();
      t0 = cyc;
      wait_irq();
      chk(8'(cyc - t0), b0);
    end
    wr_reg(a_ct, c_en | c_bq | c_nk);
    c = 0;
    repeat (40) begin
      @(posedge clk);
      #1 c += (irq === 1'b1);
    end
    chk(8'(c), 8'h00);
    rd_reg(a_ct, v);
    chk(v, c_en | c_bq | c_nk);
    done(6);
    final_report();
  end
endmodule
